// ===== pad_pkg.sv
// pad_pkg: constants, register map and destination codes of the processor address decoder.
// assumes a 40-bit processor address and a 32-bit AHB-Lite register port.
package pad_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_SMM_TOP   = 8'h04;
  localparam logic [7:0] OFS_SEG_SIZE  = 8'h08;
  localparam logic [7:0] OFS_TOP_OF_LOW_MEMORY      = 8'h0C;
  localparam logic [7:0] OFS_CFG_BASE  = 8'h10;
  localparam logic [7:0] OFS_IOAPIC    = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_RANGE0    = 8'h20;
  localparam logic [7:0] OFS_PORT0     = 8'h40;
  localparam logic [7:0] OFS_PORT_END  = 8'hC0;

  // control register fields
  localparam int CTRL_HOLE_EN   = 0;
  localparam int CTRL_GLOBAL_EN = 1;
  localparam int CTRL_HIGH_EN   = 2;
  localparam int CTRL_SEG_EN    = 3;
  localparam int CTRL_OPEN      = 4;
  localparam int CTRL_CLOSED    = 5;
  localparam int CTRL_LOCKED    = 6;
  localparam int CTRL_W         = 7;

  // other field positions
  localparam int RANGE_BRIDGE_LSB = 24;
  localparam int IOAPIC_PORT_LSB  = 1;
  localparam int STAT_LEGACY_BIT  = 8;
  localparam int STAT_COUNT_LSB   = 16;

  // reset values
  localparam logic [6:0]  CTRL_RST  = 7'h00;
  localparam logic [19:0] MB_RST    = 20'h00000;
  localparam logic [19:0] LIMIT_RST = 20'hFFFFF;

  // fixed address map
  localparam logic [39:0] HOLE_LO    = 40'h00_00F0_0000;
  localparam logic [39:0] HOLE_HI    = 40'h00_00FF_FFFF;
  localparam logic [39:0] LOWMEM_LO  = 40'h00_0100_0000;
  localparam logic [39:0] INTREG_LO  = 40'h00_FE00_0000;
  localparam logic [39:0] INTREG_HI  = 40'h00_FEBF_FFFF;
  localparam logic [39:0] IOAPIC_LO  = 40'h00_FEC0_0000;
  localparam logic [39:0] IOAPIC_HI  = 40'h00_FEC8_FFFF;
  localparam logic [39:0] TIMER_LO   = 40'h00_FEC9_0000;
  localparam logic [39:0] TIMER_HI   = 40'h00_FED1_FFFF;
  localparam logic [39:0] HSMM_LO    = 40'h00_FEDA_0000;
  localparam logic [39:0] HSMM_HI    = 40'h00_FEDB_FFFF;
  localparam logic [39:0] INTR_LO    = 40'h00_FEE0_0000;
  localparam logic [39:0] INTR_HI    = 40'h00_FEEF_FFFF;
  localparam logic [39:0] FW_LO      = 40'h00_FF00_0000;
  localparam logic [39:0] FW_HI      = 40'h00_FFFF_FFFF;
  localparam logic [39:0] HIMEM_LO   = 40'h01_0000_0000;
  localparam logic [39:0] INTREG_SPAN_DEF = 40'h00_0000_1000;

  typedef enum logic [3:0] {
    DEST_NONE,
    DEST_MEMORY,
    DEST_PORT,
    DEST_HUB,
    DEST_HUB_ABORT,
    DEST_SMM_ABORT,
    DEST_CONFIG,
    DEST_INTERNAL,
    DEST_FSB
  } pad_dest_e;

endpackage

// ===== pad_decoder.sv
// pad_decoder: picks one destination for each processor request in the upper memory map,
// with its configuration held in registers on an AHB-Lite slave port.
// assumes requests arrive synchronous to clock, at most one per cycle, and need no back-pressure.
//
// Behaviour
// R1: hole range goes to memory when hole enable is 0, else to hub link.
// R2: 16M up to segment base, and segment top up to low-memory top, go to memory.
// R3: extended segment goes to memory on a valid SMM access or when disabled.
// R4: extended segment is master aborted when SMM access is denied.
// R5: low MMIO hitting a legal port base/limit window goes to that port.
// R6: low MMIO hitting no window is sent to hub link for master abort.
// R7: the 256MB configuration window becomes a configuration access.
// R8: internal register region hits on a valid register become internal config accesses.
// R9: internal register region misses are sent to hub link for master abort.
// R10: interrupt-controller registers go non-coherently to a port or hub link per mapping.
// R11: timer and firmware regions go to the hub link.
// R12: high SMM range goes to memory on a valid SMM access or when disabled.
// R13: high SMM range is master aborted when SMM access is denied.
// R14: interrupt messages go to the processor bus; memory accesses there are aborted via hub.
// R15: 4G up to the last interleave limit goes coherently to memory.
// R16: software sets unused interleave limits equal to the highest functional one.
// R17: prefetch window with upper bits, inclusive both ends, selects that port.
// R18: anything unmatched goes to the hub link by subtractive decode.
// R19: SMM access valid only with qualifier asserted or open, or writeback.
// R20: memory requests pick the bridge from the interleave range registers.
// R21: SMM aborts are routed to the compatibility bus for master abort.
// R22: legacy needs global and not high; high needs both; segment needs global and segment.
// R23: exactly one destination per request, specific matches before the default.
`timescale 1ns/1ps

module pad_decoder #(
  parameter int          NUM_PORTS   = 4,
  parameter int          NUM_RANGES  = 6,
  parameter logic [39:0] INTREG_SPAN = pad_pkg::INTREG_SPAN_DEF
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // processor request
  input  wire logic              req_valid,
  input  wire logic [39:0]       req_addr,
  input  wire logic              req_interrupt,
  input  wire logic              req_writeback,
  input  wire logic              smm_qualifier_n,
  // disposition
  output logic                   rsp_valid,
  output pad_pkg::pad_dest_e     rsp_dest,
  output logic [1:0]             rsp_port,
  output logic [1:0]             rsp_bridge,
  output logic                   rsp_coherent,
  output logic                   legacy_smm_enabled
);

  // configuration state
  logic [6:0]  ctrl_q,     ctrl_d;
  logic [19:0] smm_top_q,  smm_top_d;
  logic [19:0] seg_size_q, seg_size_d;
  logic [19:0] top_of_low_memory_q,     top_of_low_memory_d;
  logic [11:0] cfg_base_q, cfg_base_d;
  logic [2:0]  ioapic_q,   ioapic_d;
  logic [19:0] rng_lim_q [NUM_RANGES];
  logic [19:0] rng_lim_d [NUM_RANGES];
  logic [1:0]  rng_br_q  [NUM_RANGES];
  logic [1:0]  rng_br_d  [NUM_RANGES];
  logic [11:0] mbase_q   [NUM_PORTS];
  logic [11:0] mbase_d   [NUM_PORTS];
  logic [11:0] mlim_q    [NUM_PORTS];
  logic [11:0] mlim_d    [NUM_PORTS];
  logic [19:0] pbase_q   [NUM_PORTS];
  logic [19:0] pbase_d   [NUM_PORTS];
  logic [19:0] plim_q    [NUM_PORTS];
  logic [19:0] plim_d    [NUM_PORTS];

  // bus state
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q,   rdata_d;
  logic        ahb_take;

  // disposition state
  logic               rsp_valid_q,   rsp_valid_d;
  pad_pkg::pad_dest_e rsp_dest_q,    rsp_dest_d;
  logic [1:0]         rsp_port_q,    rsp_port_d;
  logic [1:0]         rsp_bridge_q,  rsp_bridge_d;
  logic               rsp_coh_q,     rsp_coh_d;
  logic               legacy_q,      legacy_d;
  logic [15:0]        count_q,       count_d;

  // ------------------------------------------------------------ bus slave
  // zero wait states: read data is fetched in the address phase so it stands in the data phase
  assign ahb_take  = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  always_comb begin
    logic [7:0] ra;
    logic [2:0] ri;
    logic [1:0] rp;
    ra = haddr[7:0];
    ri = ra[4:2];
    // port blocks count from the first port offset, not from address zero
    rp = 2'((ra - pad_pkg::OFS_PORT0) >> 5);
    wr_pend_d = ahb_take & hwrite & (hsize == 3'h2);
    wr_addr_d = ahb_take ? ra : wr_addr_q;
    rdata_d   = 32'h0000_0000;
    if (ahb_take && !hwrite) begin
      if (ra == pad_pkg::OFS_CTRL) begin
        rdata_d[6:0] = ctrl_q;
      end else if (ra == pad_pkg::OFS_SMM_TOP) begin
        rdata_d[19:0] = smm_top_q;
      end else if (ra == pad_pkg::OFS_SEG_SIZE) begin
        rdata_d[19:0] = seg_size_q;
      end else if (ra == pad_pkg::OFS_TOP_OF_LOW_MEMORY) begin
        rdata_d[19:0] = top_of_low_memory_q;
      end else if (ra == pad_pkg::OFS_CFG_BASE) begin
        rdata_d[11:0] = cfg_base_q;
      end else if (ra == pad_pkg::OFS_IOAPIC) begin
        rdata_d[2:0] = ioapic_q;
      end else if (ra == pad_pkg::OFS_STATUS) begin
        rdata_d[3:0] = rsp_dest_q;
        rdata_d[5:4] = rsp_port_q;
        rdata_d[pad_pkg::STAT_LEGACY_BIT] = legacy_q;
        rdata_d[pad_pkg::STAT_COUNT_LSB +: 16] = count_q;
      end else if (ra >= pad_pkg::OFS_RANGE0 && ra < pad_pkg::OFS_PORT0) begin
        if ({1'b0, ri} < 4'(NUM_RANGES)) begin
          rdata_d[19:0] = rng_lim_q[ri];
          rdata_d[pad_pkg::RANGE_BRIDGE_LSB +: 2] = rng_br_q[ri];
        end
      end else if (ra >= pad_pkg::OFS_PORT0 && ra < pad_pkg::OFS_PORT_END) begin
        case (ri)
          3'h0: rdata_d[11:0] = mbase_q[rp];
          3'h1: rdata_d[11:0] = mlim_q[rp];
          3'h2: rdata_d[11:0] = pbase_q[rp][11:0];
          3'h3: rdata_d[11:0] = plim_q[rp][11:0];
          3'h4: rdata_d[7:0]  = pbase_q[rp][19:12];
          3'h5: rdata_d[7:0]  = plim_q[rp][19:12];
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // register writes land in the data phase; unmapped offsets are ignored
  always_comb begin
    logic [2:0] wi;
    logic [1:0] wp;
    wi = wr_addr_q[4:2];
    wp = 2'((wr_addr_q - pad_pkg::OFS_PORT0) >> 5);
    ctrl_d     = ctrl_q;
    smm_top_d  = smm_top_q;
    seg_size_d = seg_size_q;
    top_of_low_memory_d     = top_of_low_memory_q;
    cfg_base_d = cfg_base_q;
    ioapic_d   = ioapic_q;
    rng_lim_d  = rng_lim_q;
    rng_br_d   = rng_br_q;
    mbase_d    = mbase_q;
    mlim_d     = mlim_q;
    pbase_d    = pbase_q;
    plim_d     = plim_q;
    if (wr_pend_q) begin
      if (wr_addr_q == pad_pkg::OFS_CTRL) begin
        ctrl_d = hwdata[6:0];
      end else if (wr_addr_q == pad_pkg::OFS_SMM_TOP) begin
        smm_top_d = hwdata[19:0];
      end else if (wr_addr_q == pad_pkg::OFS_SEG_SIZE) begin
        seg_size_d = hwdata[19:0];
      end else if (wr_addr_q == pad_pkg::OFS_TOP_OF_LOW_MEMORY) begin
        top_of_low_memory_d = hwdata[19:0];
      end else if (wr_addr_q == pad_pkg::OFS_CFG_BASE) begin
        cfg_base_d = hwdata[11:0];
      end else if (wr_addr_q == pad_pkg::OFS_IOAPIC) begin
        ioapic_d = hwdata[2:0];
      end else if (wr_addr_q >= pad_pkg::OFS_RANGE0 && wr_addr_q < pad_pkg::OFS_PORT0) begin
        if ({1'b0, wi} < 4'(NUM_RANGES)) begin
          rng_lim_d[wi] = hwdata[19:0];
          rng_br_d[wi]  = hwdata[pad_pkg::RANGE_BRIDGE_LSB +: 2];
        end
      end else if (wr_addr_q >= pad_pkg::OFS_PORT0 && wr_addr_q < pad_pkg::OFS_PORT_END) begin
        case (wi)
          3'h0: mbase_d[wp] = hwdata[11:0];
          3'h1: mlim_d[wp]  = hwdata[11:0];
          3'h2: pbase_d[wp][11:0]  = hwdata[11:0];
          3'h3: plim_d[wp][11:0]   = hwdata[11:0];
          3'h4: pbase_d[wp][19:12] = hwdata[7:0];
          3'h5: plim_d[wp][19:12]  = hwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_pend_q  <= 1'b0;
      wr_addr_q  <= 8'h00;
      rdata_q    <= 32'h0000_0000;
      ctrl_q     <= pad_pkg::CTRL_RST;
      smm_top_q  <= pad_pkg::MB_RST;
      seg_size_q <= pad_pkg::MB_RST;
      top_of_low_memory_q     <= pad_pkg::MB_RST;
      cfg_base_q <= pad_pkg::MB_RST[11:0];
      ioapic_q   <= 3'h0;
      for (int i = 0; i < NUM_RANGES; i++) begin
        rng_lim_q[i] <= pad_pkg::LIMIT_RST;
        rng_br_q[i]  <= 2'h0;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        mbase_q[p] <= pad_pkg::LIMIT_RST[11:0];
        mlim_q[p]  <= pad_pkg::MB_RST[11:0];
        pbase_q[p] <= pad_pkg::LIMIT_RST;
        plim_q[p]  <= pad_pkg::MB_RST;
      end
    end else begin
      wr_pend_q  <= wr_pend_d;
      wr_addr_q  <= wr_addr_d;
      rdata_q    <= rdata_d;
      ctrl_q     <= ctrl_d;
      smm_top_q  <= smm_top_d;
      seg_size_q <= seg_size_d;
      top_of_low_memory_q     <= top_of_low_memory_d;
      cfg_base_q <= cfg_base_d;
      ioapic_q   <= ioapic_d;
      rng_lim_q  <= rng_lim_d;
      rng_br_q   <= rng_br_d;
      mbase_q    <= mbase_d;
      mlim_q     <= mlim_d;
      pbase_q    <= pbase_d;
      plim_q     <= plim_d;
    end
  end

  // ------------------------------------------------------------ port window match
  logic [19:0]          mb;
  logic [NUM_PORTS-1:0] low_hit;
  logic [NUM_PORTS-1:0] pf_hit;
  assign mb = req_addr[39:20];

  // a window whose base is above its limit is not legal and never matches
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign low_hit[p] = (mbase_q[p] <= mlim_q[p]) && (mb[19:12] == 8'h00) &&
                        (mb[11:0] >= mbase_q[p]) && (mb[11:0] <= mlim_q[p]);
    assign pf_hit[p]  = (pbase_q[p] <= plim_q[p]) && (mb >= pbase_q[p]) && (mb <= plim_q[p]); // R17
  end

  // ------------------------------------------------------------ region decode
  logic [19:0] seg_lo;
  logic in_hole, in_lowmem, in_seg, in_lmmio, in_cfg, in_intreg, reg_ok, in_ioapic;
  logic in_timer, in_hsmm, in_intr, in_fw, in_himem, smm_grant, seg_en, hsmm_en;

  assign seg_lo    = smm_top_q - seg_size_q;
  assign in_hole   = (req_addr >= pad_pkg::HOLE_LO) && (req_addr <= pad_pkg::HOLE_HI);
  assign in_lowmem = (req_addr >= pad_pkg::LOWMEM_LO) && (mb < top_of_low_memory_q) &&
                     ((mb < seg_lo) || (mb >= smm_top_q));
  assign in_seg    = (mb >= seg_lo) && (mb < smm_top_q) && (req_addr >= pad_pkg::LOWMEM_LO);
  assign in_lmmio  = (mb >= top_of_low_memory_q) && (req_addr < pad_pkg::INTREG_LO);
  assign in_cfg    = (req_addr[39:28] == cfg_base_q);
  assign in_intreg = (req_addr >= pad_pkg::INTREG_LO) && (req_addr <= pad_pkg::INTREG_HI);
  assign reg_ok    = (req_addr - pad_pkg::INTREG_LO) < INTREG_SPAN;
  assign in_ioapic = (req_addr >= pad_pkg::IOAPIC_LO) && (req_addr <= pad_pkg::IOAPIC_HI);
  assign in_timer  = (req_addr >= pad_pkg::TIMER_LO) && (req_addr <= pad_pkg::TIMER_HI);
  assign in_hsmm   = (req_addr >= pad_pkg::HSMM_LO) && (req_addr <= pad_pkg::HSMM_HI);
  assign in_intr   = (req_addr >= pad_pkg::INTR_LO) && (req_addr <= pad_pkg::INTR_HI);
  assign in_fw     = (req_addr >= pad_pkg::FW_LO) && (req_addr <= pad_pkg::FW_HI);
  // the last interleave limit is the top of memory even if that range is unused
  assign in_himem  = (req_addr >= pad_pkg::HIMEM_LO) && (mb <= rng_lim_q[NUM_RANGES-1]); // R15 R16

  // a locked space ignores the open bit; writebacks are always let through
  assign smm_grant = req_writeback | ~smm_qualifier_n |
                     (ctrl_q[pad_pkg::CTRL_OPEN] & ~ctrl_q[pad_pkg::CTRL_LOCKED]); // R19
  assign seg_en    = ctrl_q[pad_pkg::CTRL_GLOBAL_EN] & ctrl_q[pad_pkg::CTRL_SEG_EN]; // R22
  assign hsmm_en   = ctrl_q[pad_pkg::CTRL_GLOBAL_EN] & ctrl_q[pad_pkg::CTRL_HIGH_EN]; // R22

  always_comb begin
    logic       found;
    logic [1:0] pick;
    found = 1'b0;
    pick  = 2'h0;
    for (int p = NUM_PORTS - 1; p >= 0; p--) begin
      if (low_hit[p] || pf_hit[p]) begin
        found = 1'b1;
        pick  = 2'(p);
      end
    end
    rsp_bridge_d = rsp_bridge_q;
    for (int i = NUM_RANGES - 1; i >= 0; i--) begin
      if (mb <= rng_lim_q[i]) begin
        rsp_bridge_d = rng_br_q[i]; // R20
      end
    end
    rsp_valid_d = req_valid;
    rsp_port_d  = rsp_port_q;
    rsp_coh_d   = 1'b0;
    rsp_dest_d  = rsp_dest_q;
    legacy_d    = ctrl_q[pad_pkg::CTRL_GLOBAL_EN] & ~ctrl_q[pad_pkg::CTRL_HIGH_EN]; // R22
    count_d     = count_q + 16'(req_valid);
    if (req_valid) begin
      // one branch only: the hole range first, subtractive decode last
      if (in_hole) begin // R23
        rsp_dest_d = ctrl_q[pad_pkg::CTRL_HOLE_EN] ? pad_pkg::DEST_HUB : pad_pkg::DEST_MEMORY; // R1
      end else if (in_seg) begin
        rsp_dest_d = (!seg_en || smm_grant) ? pad_pkg::DEST_MEMORY : pad_pkg::DEST_SMM_ABORT; // R3 R4 R21
      end else if (in_lowmem) begin
        rsp_dest_d = pad_pkg::DEST_MEMORY; // R2
      end else if (in_cfg) begin
        rsp_dest_d = pad_pkg::DEST_CONFIG; // R7
      end else if (in_lmmio) begin
        rsp_dest_d = found ? pad_pkg::DEST_PORT : pad_pkg::DEST_HUB_ABORT; // R5 R6
        rsp_port_d = pick;
      end else if (in_intreg) begin
        rsp_dest_d = reg_ok ? pad_pkg::DEST_INTERNAL : pad_pkg::DEST_HUB_ABORT; // R8 R9
      end else if (in_ioapic) begin
        rsp_dest_d = ioapic_q[0] ? pad_pkg::DEST_PORT : pad_pkg::DEST_HUB; // R10
        rsp_port_d = ioapic_q[pad_pkg::IOAPIC_PORT_LSB +: 2];
      end else if (in_timer || in_fw) begin
        rsp_dest_d = pad_pkg::DEST_HUB; // R11
      end else if (in_hsmm) begin
        rsp_dest_d = (!hsmm_en || smm_grant) ? pad_pkg::DEST_MEMORY : pad_pkg::DEST_SMM_ABORT; // R12 R13 R21
      end else if (in_intr) begin
        rsp_dest_d = req_interrupt ? pad_pkg::DEST_FSB : pad_pkg::DEST_HUB_ABORT; // R14
      end else if (in_himem) begin
        rsp_dest_d = pad_pkg::DEST_MEMORY; // R15
      end else if (found && req_addr >= pad_pkg::HIMEM_LO && pf_hit[pick]) begin
        rsp_dest_d = pad_pkg::DEST_PORT; // R17
        rsp_port_d = pick;
      end else begin
        rsp_dest_d = pad_pkg::DEST_HUB; // R18
      end
      rsp_coh_d = (rsp_dest_d == pad_pkg::DEST_MEMORY);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rsp_valid_q  <= 1'b0;
      rsp_dest_q   <= pad_pkg::DEST_NONE;
      rsp_port_q   <= 2'h0;
      rsp_bridge_q <= 2'h0;
      rsp_coh_q    <= 1'b0;
      legacy_q     <= 1'b0;
      count_q      <= 16'h0000;
    end else begin
      rsp_valid_q  <= rsp_valid_d;
      rsp_dest_q   <= rsp_dest_d;
      rsp_port_q   <= rsp_port_d;
      rsp_bridge_q <= rsp_bridge_d;
      rsp_coh_q    <= rsp_coh_d;
      legacy_q     <= legacy_d;
      count_q      <= count_d;
    end
  end

  assign rsp_valid          = rsp_valid_q;
  assign rsp_dest           = rsp_dest_q;
  assign rsp_port           = rsp_port_q;
  assign rsp_bridge         = rsp_bridge_q;
  assign rsp_coherent       = rsp_coh_q;
  assign legacy_smm_enabled = legacy_q;

  // ------------------------------------------------------------ checks
  property p_hole;
    @(posedge clock) disable iff (rst)
    req_valid && in_hole |=> rsp_dest == ($past(ctrl_q[pad_pkg::CTRL_HOLE_EN]) ? pad_pkg::DEST_HUB
                                                                                : pad_pkg::DEST_MEMORY);
  endproperty
  a_hole: assert property (p_hole) else $error("hole routed wrongly"); // R1

  property p_seg_abort;
    @(posedge clock) disable iff (rst)
    req_valid && in_seg && !in_hole && seg_en && !smm_grant |=> rsp_dest == pad_pkg::DEST_SMM_ABORT;
  endproperty
  a_seg_abort: assert property (p_seg_abort) else $error("denied segment access not aborted"); // R4

  property p_hsmm;
    @(posedge clock) disable iff (rst)
    req_valid && in_hsmm && (!hsmm_en || smm_grant) |=> rsp_dest == pad_pkg::DEST_MEMORY && rsp_coherent;
  endproperty
  a_hsmm: assert property (p_hsmm) else $error("high smm access not sent to memory"); // R12

  property p_hsmm_abort;
    @(posedge clock) disable iff (rst)
    req_valid && in_hsmm && hsmm_en && !smm_grant |=> rsp_dest == pad_pkg::DEST_SMM_ABORT;
  endproperty
  a_hsmm_abort: assert property (p_hsmm_abort) else $error("denied high smm access not aborted"); // R13

  property p_intr;
    @(posedge clock) disable iff (rst)
    req_valid && in_intr |=> rsp_dest == ($past(req_interrupt) ? pad_pkg::DEST_FSB : pad_pkg::DEST_HUB_ABORT);
  endproperty
  a_intr: assert property (p_intr) else $error("interrupt range routed wrongly"); // R14

  property p_hub_fixed;
    @(posedge clock) disable iff (rst)
    req_valid && (in_timer || in_fw) |=> rsp_dest == pad_pkg::DEST_HUB;
  endproperty
  a_hub_fixed: assert property (p_hub_fixed) else $error("timer or firmware not sent to hub link"); // R11

  property p_one_dest;
    @(posedge clock) disable iff (rst)
    req_valid |=> rsp_valid && rsp_dest != pad_pkg::DEST_NONE ##1 rsp_valid == $past(req_valid);
  endproperty
  a_one_dest: assert property (p_one_dest) else $error("request without a single destination"); // R23

  property p_coh;
    @(posedge clock) disable iff (rst)
    rsp_valid |-> rsp_coherent == (rsp_dest == pad_pkg::DEST_MEMORY);
  endproperty
  a_coh: assert property (p_coh) else $error("coherence flag disagrees with destination"); // R10 R15

  property p_legacy;
    @(posedge clock) disable iff (rst)
    ##1 legacy_smm_enabled == ($past(ctrl_q[pad_pkg::CTRL_GLOBAL_EN]) && !$past(ctrl_q[pad_pkg::CTRL_HIGH_EN]));
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy smm enable wrong"); // R22

endmodule

// ===== pad_fsb_model.sv
// pad_fsb_model: processor bus requester that feeds the decoder one request at a time.
// assumes the decoder takes a request on every edge with req_valid high and never stalls.
`timescale 1ns/1ps

module pad_fsb_model (
  // clock
  input  wire logic clock,
  // request to the decoder
  output logic        req_valid,
  output logic [39:0] req_addr,
  output logic        req_interrupt,
  output logic        req_writeback,
  output logic        smm_qualifier_n
);
  initial begin
    {req_valid, req_interrupt, req_writeback, smm_qualifier_n} = 4'h1;
    req_addr = 40'h00_0000_0000;
  end

  // flags are {interrupt, writeback, qualifier_n}; one pulse per request
  task automatic issue(input logic [39:0] a, input logic [2:0] f);
    @(posedge clock);
    req_valid <= 1'b1;
    req_addr <= a;
    {req_interrupt, req_writeback, smm_qualifier_n} <= f;
    @(posedge clock);
    // released lines show the inverse so a stale value cannot pass for a fresh one
    req_valid <= 1'b0;
    req_addr <= ~a;
    {req_interrupt, req_writeback, smm_qualifier_n} <= ~f;
  endtask
endmodule

// ===== pad_decoder_test.sv
// pad_decoder_test: self-checking bench for the processor address decoder.
// assumes it is the only AHB-Lite master and drives requests through pad_fsb_model.
`timescale 1ns/1ps

module pad_decoder_test;
  logic               clock, rst, hsel, hwrite, hready, hreadyout, hresp, rsp_valid, rsp_coherent;
  logic               legacy_smm_enabled, req_valid, req_interrupt, req_writeback, smm_qualifier_n;
  logic [1:0]         htrans, rsp_port, rsp_bridge;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic [39:0]        req_addr;
  int                 fails, samples_checked;
  pad_pkg::pad_dest_e rsp_dest;

  assign hready = hreadyout;
  always #25 clock = ~clock;

  pad_decoder u_pad_decoder (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .req_valid, .req_addr, .req_interrupt, .req_writeback, .smm_qualifier_n,
    .rsp_valid, .rsp_dest, .rsp_port, .rsp_bridge, .rsp_coherent, .legacy_smm_enabled);
  pad_fsb_model u_pad_fsb_model (.clock, .req_valid, .req_addr, .req_interrupt, .req_writeback,
    .smm_qualifier_n);

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // single word transfer; read data lands in rd
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {hsel, htrans, hwrite, hsize, haddr} <= {1'b1, 2'h2, w, 3'h2, 24'h00_0000, a};
    do @(posedge clock); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task dec(input logic [39:0] a, input logic [2:0] f, input pad_pkg::pad_dest_e e);
    u_pad_fsb_model.issue(a, f);
    #1;
    chk({31'h0, rsp_valid}, 32'h1);
    chk(32'(rsp_dest), 32'(e));
    chk({31'h0, rsp_coherent}, {31'h0, e == pad_pkg::DEST_MEMORY});
  endtask

  task t_regs;
    rdc(8'h00, 32'h0);
    rdc(8'h20, 32'h000F_FFFF);
    ahb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    rdc(8'hFC, 32'h0);
    ahb(1'b1, 8'h00, 32'h2);
    @(posedge clock);
    #1;
    chk({31'h0, legacy_smm_enabled}, 32'h1);
    rdc(8'h00, 32'h2);
  endtask

  task t_hole;
    ahb(1'b1, 8'h00, 32'h0);
    dec(40'h00_00F0_0000, 3'h1, pad_pkg::DEST_MEMORY);
    ahb(1'b1, 8'h00, 32'h1);
    dec(40'h00_00FF_FFFF, 3'h1, pad_pkg::DEST_HUB);
  endtask

  task t_map;
    ahb(1'b1, 8'h00, 32'h0E);
    for (int i = 0; i < 6; i++) ahb(1'b1, 8'(8'h20 + 4 * i), 32'h0200_2FFF);
    ahb(1'b1, 8'h04, 32'h7F0);
    ahb(1'b1, 8'h08, 32'h10);
    ahb(1'b1, 8'h0C, 32'h800);
    ahb(1'b1, 8'h10, 32'hC);
    ahb(1'b1, 8'h40, 32'h900);
    ahb(1'b1, 8'h44, 32'h90F);
    ahb(1'b1, 8'h68, 32'h0);
    ahb(1'b1, 8'h6C, 32'h0FF);
    ahb(1'b1, 8'h70, 32'h4);
    ahb(1'b1, 8'h74, 32'h4);
    dec(40'h00_0100_0000, 3'h1, pad_pkg::DEST_MEMORY);
    chk({30'h0, rsp_bridge}, 32'h2);
    dec(40'h00_7F00_0000, 3'h1, pad_pkg::DEST_MEMORY);
    dec(40'h00_7E00_0000, 3'h1, pad_pkg::DEST_SMM_ABORT);
    dec(40'h00_7EFF_FFFF, 3'h0, pad_pkg::DEST_MEMORY);
    dec(40'h00_9000_0000, 3'h1, pad_pkg::DEST_PORT);
    chk({30'h0, rsp_port}, 32'h0);
    dec(40'h00_9100_0000, 3'h1, pad_pkg::DEST_HUB_ABORT);
    dec(40'h00_CFFF_FFFF, 3'h1, pad_pkg::DEST_CONFIG);
    dec(40'h00_FE00_0000, 3'h1, pad_pkg::DEST_INTERNAL);
    dec(40'h00_FE00_1000, 3'h1, pad_pkg::DEST_HUB_ABORT);
    dec(40'h00_FEC8_FFFF, 3'h1, pad_pkg::DEST_HUB);
    dec(40'h00_FEC9_0000, 3'h1, pad_pkg::DEST_HUB);
    dec(40'h00_FF00_0000, 3'h1, pad_pkg::DEST_HUB);
    dec(40'h00_FEDB_FFFF, 3'h1, pad_pkg::DEST_SMM_ABORT);
    dec(40'h00_FEDA_0000, 3'h3, pad_pkg::DEST_MEMORY);
    dec(40'h00_FEE0_0000, 3'h5, pad_pkg::DEST_FSB);
    dec(40'h00_FEEF_FFFF, 3'h1, pad_pkg::DEST_HUB_ABORT);
    dec(40'h01_0000_0000, 3'h1, pad_pkg::DEST_MEMORY);
    dec(40'h03_0000_0000, 3'h1, pad_pkg::DEST_HUB);
    dec(40'h04_0FFF_FFFF, 3'h1, pad_pkg::DEST_PORT);
    chk({30'h0, rsp_port}, 32'h1);
  endtask

  task t_smm;
    ahb(1'b1, 8'h00, 32'h1E);
    dec(40'h00_7E00_0000, 3'h1, pad_pkg::DEST_MEMORY);
    ahb(1'b1, 8'h00, 32'h5E);
    dec(40'h00_7E00_0000, 3'h1, pad_pkg::DEST_SMM_ABORT);
    ahb(1'b1, 8'h00, 32'h0A);
    dec(40'h00_FEDA_0000, 3'h1, pad_pkg::DEST_MEMORY);
    ahb(1'b1, 8'h00, 32'h0);
    dec(40'h00_7E00_0000, 3'h1, pad_pkg::DEST_MEMORY);
    rdc(8'h18, 32'h0019_0011);
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    fails = 0;
    samples_checked = 0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs;
    t_hole;
    t_map;
    t_smm;
    close_out;
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    close_out;
  end
endmodule
